// ===== clock_pair_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// input clock pair
// ----
module clock_pair_model (
   // faults
   input  wire kill_pri,
   input  wire kill_sec,
   // clocks
   output reg  clk_primary,
   output reg  clk_secondary
);
   // a dead clock stands at its last level
   initial begin
      clk_primary = 1'b0;
      #3;
      forever #80 if (!kill_pri) clk_primary = ~clk_primary;
   end
   initial begin
      clk_secondary = 1'b0;
      #41;
      forever #80 if (!kill_sec) clk_secondary = ~clk_secondary;
   end
endmodule // clock_pair_model
`default_nettype wire

// ===== clock_select_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "clock_select_defs.vh"
// ----
// port checks
// ----
module clock_select_checker (
   input wire        clk_sys,
   input wire        rst_n,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire        pready,
   input wire        pslverr,
   input wire        clk_primary,
   input wire        clk_secondary,
   input wire [3:0]  clock_out_p,
   input wire [3:0]  clock_out_n
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // control word as last written over the bus
   reg  [4:0] seen_ctrl_r;
   wire       gated_seen = seen_ctrl_r[`CS_HOLD_BIT] | seen_ctrl_r[`CS_SLEEP_BIT];
   always @(posedge clk_sys) begin
      if (!rst_n) begin
         seen_ctrl_r <= `CS_CTRL_RST;
      end else if (psel && penable && pready && pwrite && paddr == `CS_CTRL_OFS) begin
         seen_ctrl_r <= pwdata[4:0];
      end
   end
   a_outs_same: assert property (clock_out_p == 4'h0 || clock_out_p == 4'hf)
      else $error("outputs differ");
   a_pair_sides: assert property (clock_out_n == ~clock_out_p || clock_out_n == 4'hf)
      else $error("bad pair");
   a_rise_cause: assert property ($rose(clock_out_p[0]) && !gated_seen && !$past(gated_seen) |->
      $past(clk_primary | clk_secondary, 4)) else $error("rise without input");
   a_ready_pulse: assert property (pready |=> !pready) else $error("long ready");
   a_ready_cause: assert property (pready |-> $past(psel && penable)) else $error("stray ready");
   a_err_ready: assert property (pslverr |-> pready) else $error("stray error");
   a_err_decode: assert property (pready |-> pslverr == (paddr != 12'h000 && paddr != 12'h004))
      else $error("bad decode");
   a_rdata_top: assert property (pready && !pwrite |-> prdata[31:6] == 26'h0)
      else $error("bad upper bits");
   c_rise: cover property ($rose(clock_out_p[0]));
   c_err: cover property (pslverr);
   c_sleep: cover property (clock_out_p == 4'hf && clock_out_n == 4'hf);
endmodule // clock_select_checker
bind glitchless_clock_select clock_select_checker i_clock_select_checker (
   .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .clk_primary(clk_primary), .clk_secondary(clk_secondary),
   .clock_out_p(clock_out_p), .clock_out_n(clock_out_n));
`default_nettype wire

// ===== clock_select_defs.vh
`ifndef CLOCK_SELECT_DEFS_VH
`define CLOCK_SELECT_DEFS_VH
// register byte offsets
`define CS_CTRL_OFS    12'h000
`define CS_STATUS_OFS  12'h004
// control field positions
`define CS_SEL_BIT     0
`define CS_FORCE_BIT   1
`define CS_HOLD_BIT    2
`define CS_POL_BIT     3
`define CS_SLEEP_BIT   4
`define CS_CTRL_RST    5'h00
// falling edges of the new clock spent low during a switchover
`define CS_HOLD_FALLS  2'h2
// default falling edges of the new clock before restart after force
`define CS_FORCE_FALLS 4
`endif

// ===== glitchless_clock_select.v
// Function
// - output drops low at its falling edge
// - low hold through two falling edges of the new clock
// - restart on new clock rising edge
// - dead chosen clock freezes output at a fixed level
// - forced restart after some new cycles
// - force high ignores the unchosen clock
// - force drives low now, then restarts
// - asynchronous hold may give runt pulses
// - sleep pulls both output sides high
// - hold drives p outputs to polarity level, n outputs to its inverse
`timescale 1ns/1ps
`default_nettype none
`include "clock_select_defs.vh"
module glitchless_clock_select #(
   parameter FORCE_FALLS = `CS_FORCE_FALLS
) (
   // system
   input  wire        clk_sys,
   input  wire        rst_n,
   // input clocks
   input  wire        clk_primary,
   input  wire        clk_secondary,
   // apb slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // clock outputs
   output reg  [3:0]  clock_out_p,
   output reg  [3:0]  clock_out_n
);

   // -----------------------------
   // states
   // -----------------------------
   localparam [3:0] ST_RUN   = 4'h1;
   localparam [3:0] ST_DRAIN = 4'h2;
   localparam [3:0] ST_HOLD  = 4'h4;
   localparam [3:0] ST_FORCE = 4'h8;

   reg  [4:0]  ctrl_r;
   reg  [1:0]  pri_sync_r;
   reg  [1:0]  sec_sync_r;
   reg         pri_prev_r;
   reg         sec_prev_r;
   reg  [3:0]  state_r;
   reg  [3:0]  state_nxt;
   reg         cur_src_r;
   reg         cur_src_nxt;
   reg         gclk_r;
   reg         gclk_nxt;
   reg         force_prev_r;
   reg  [7:0]  cnt_r;
   reg  [7:0]  cnt_nxt;

   wire        sel_bit   = ctrl_r[`CS_SEL_BIT];
   wire        force_bit = ctrl_r[`CS_FORCE_BIT];
   wire        hold_bit  = ctrl_r[`CS_HOLD_BIT];
   wire        pol_bit   = ctrl_r[`CS_POL_BIT];
   wire        sleep_bit = ctrl_r[`CS_SLEEP_BIT];
   wire        force_rise = force_bit & ~force_prev_r;

   // -----------------------------
   // clock sampling
   // -----------------------------
   always @(posedge clk_sys) begin
      if (!rst_n) begin
         pri_sync_r <= 2'h0;
         sec_sync_r <= 2'h0;
         pri_prev_r <= 1'b0;
         sec_prev_r <= 1'b0;
      end else begin
         pri_sync_r <= {pri_sync_r[0], clk_primary};
         sec_sync_r <= {sec_sync_r[0], clk_secondary};
         pri_prev_r <= pri_sync_r[1];
         sec_prev_r <= sec_sync_r[1];
      end
   end

   function level_of;
      input src;
      input lvl_pri;
      input lvl_sec;
      begin
         level_of = src ? lvl_sec : lvl_pri;
      end
   endfunction

   function [7:0] bump;
      input [7:0] v;
      begin
         bump = v + 8'h01;
      end
   endfunction

   wire cur_lvl  = level_of(cur_src_r, pri_sync_r[1], sec_sync_r[1]);
   wire cur_prev = level_of(cur_src_r, pri_prev_r, sec_prev_r);
   wire cur_fall = ~cur_lvl & cur_prev;

   // -----------------------------
   // select state machine
   // -----------------------------
   always @* begin
      state_nxt   = state_r;
      cur_src_nxt = cur_src_r;
      gclk_nxt    = gclk_r;
      cnt_nxt     = cnt_r;
      case (state_r)
         ST_RUN: begin
            gclk_nxt = cur_lvl;
            if (force_rise) begin
               gclk_nxt    = 1'b0;
               cur_src_nxt = sel_bit;
               cnt_nxt     = 8'h00;
               state_nxt   = ST_FORCE;
            end else if (!force_bit && sel_bit != cur_src_r) begin
               state_nxt = ST_DRAIN;
            end
         end
         ST_DRAIN: begin
            gclk_nxt = cur_lvl;
            if (force_rise) begin
               gclk_nxt    = 1'b0;
               cur_src_nxt = sel_bit;
               cnt_nxt     = 8'h00;
               state_nxt   = ST_FORCE;
            end else if (!cur_lvl) begin
               gclk_nxt    = 1'b0;
               cur_src_nxt = sel_bit;
               cnt_nxt     = 8'h00;
               state_nxt   = ST_HOLD;
            end
         end
         ST_HOLD: begin
            gclk_nxt = 1'b0;
            if (force_rise) begin
               cur_src_nxt = sel_bit;
               cnt_nxt     = 8'h00;
               state_nxt   = ST_FORCE;
            end else if (cur_fall) begin
               cnt_nxt = bump(cnt_r);
               if (cnt_r[1:0] == `CS_HOLD_FALLS - 2'h1) begin
                  state_nxt = ST_RUN;
               end
            end
         end
         ST_FORCE: begin
            gclk_nxt = 1'b0;
            if (cur_fall) begin
               cnt_nxt = bump(cnt_r);
               if (cnt_r == FORCE_FALLS[7:0] - 8'h01) begin
                  state_nxt = ST_RUN;
               end
            end
         end
         default: begin
            gclk_nxt  = 1'b0;
            state_nxt = ST_RUN;
         end
      endcase
   end

   always @(posedge clk_sys) begin
      if (!rst_n) begin
         state_r      <= ST_RUN;
         cur_src_r    <= 1'b0;
         gclk_r       <= 1'b0;
         cnt_r        <= 8'h00;
         force_prev_r <= 1'b0;
      end else begin
         state_r      <= state_nxt;
         cur_src_r    <= cur_src_nxt;
         gclk_r       <= gclk_nxt;
         cnt_r        <= cnt_nxt;
         force_prev_r <= force_bit;
      end
   end

   // -----------------------------
   // output stage
   // -----------------------------
   always @(posedge clk_sys) begin
      if (!rst_n) begin
         clock_out_p <= 4'h0;
         clock_out_n <= 4'hf;
      end else if (sleep_bit) begin
         clock_out_p <= 4'hf;
         clock_out_n <= 4'hf;
      end else if (hold_bit) begin
         clock_out_p <= {4{pol_bit}};
         clock_out_n <= {4{~pol_bit}};
      end else begin
         clock_out_p <= {4{gclk_r}};
         clock_out_n <= {4{~gclk_r}};
      end
   end

   // -----------------------------
   // apb slave
   // -----------------------------
   wire acc    = psel & penable & ~pready;
   wire hit_c  = (paddr == `CS_CTRL_OFS);
   wire hit_s  = (paddr == `CS_STATUS_OFS);

   always @(posedge clk_sys) begin
      if (!rst_n) begin
         ctrl_r  <= `CS_CTRL_RST;
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= acc;
         pslverr <= acc & ~hit_c & ~hit_s;
         if (acc && pwrite && hit_c) begin
            ctrl_r <= pwdata[4:0];
         end
         if (acc && !pwrite && hit_c) begin
            prdata <= {27'h0, ctrl_r};
         end else if (acc && !pwrite && hit_s) begin
            prdata <= {26'h0, state_r, gclk_r, cur_src_r};
         end else if (acc) begin
            prdata <= 32'h0000_0000;
         end
      end
   end

endmodule // glitchless_clock_select
`default_nettype wire

// ===== tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   // ----
   // bench
   // ----
   reg         clk_sys = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   reg         kill_pri = 1'b0, kill_sec = 1'b0, p0;
   reg  [11:0] paddr = 12'h000;
   reg  [31:0] pwdata = 32'h0, d, lv = 32'h0c04101c, lx = 32'hf00fffff;
   reg  [32:0] expq [$];
   wire        clk_primary, clk_secondary, pready, pslverr;
   wire [31:0] prdata;
   wire [3:0]  clock_out_p, clock_out_n;
   integer     errors = 0, n_compared = 0, seed = 32'hfb7e, i, n;
   initial forever #10 clk_sys = ~clk_sys;
   glitchless_clock_select #(.FORCE_FALLS(2)) i_glitchless_clock_select (
      .clk_sys(clk_sys), .rst_n(rst_n), .clk_primary(clk_primary),
      .clk_secondary(clk_secondary), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .clock_out_p(clock_out_p), .clock_out_n(clock_out_n));
   clock_pair_model i_clock_pair_model (.kill_pri(kill_pri), .kill_sec(kill_sec),
      .clk_primary(clk_primary), .clk_secondary(clk_secondary));
   task final_report;
      $display("errors %0d compared %0d", errors, n_compared);
      if (errors == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task cmp_word(input [32:0] x, input [32:0] g);
      n_compared = n_compared + 1;
      if (g !== x) begin
         errors = errors + 1;
         $display("ERROR %0t exp %h got %h", $time, x, g);
      end
   endtask
   task cmp_pins(input [7:0] x, input [7:0] g);
      cmp_word({25'h0, x}, {25'h0, g});
   endtask
   task bus(input w, input [11:0] a, input [31:0] wd, input [32:0] x);
      if (!w) expq.push_back(x);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk_sys);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_sys);
         n = n + 1;
      end while (pready !== 1'b1 && n < 20);
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         errors = errors + 1;
         final_report;
      end
      @(posedge clk_sys);
   endtask
   // counts output rises after a control write
   task run(input [31:0] c);
      bus(1'b1, 12'h000, c, 33'h0);
      repeat (60) @(posedge clk_sys);
      n = 0;
      p0 = clock_out_p[0];
      repeat (64) begin
         @(posedge clk_sys);
         if (clock_out_p[0] === 1'b1 && p0 === 1'b0) n = n + 1;
         p0 = clock_out_p[0];
      end
      cmp_pins(8'h01, {7'h0, n >= 7});
   endtask
   always @(posedge clk_sys)
      if (pready === 1'b1 && pwrite === 1'b0) cmp_word(expq.pop_front(), {pslverr, prdata});
   initial begin
      repeat (10) @(posedge clk_sys);
      rst_n <= 1'b1;
      @(posedge clk_sys);
      bus(1'b0, 12'h000, 32'h0, 33'h0);
      for (i = 0; i < 4; i = i + 1) begin
         d = $random(seed);
         bus(1'b1, 12'h000, d, 33'h0);
         bus(1'b0, 12'h000, 32'h0, {28'h0, d[4:0]});
      end
      bus(1'b1, 12'h008, 32'h1f, 33'h0);
      bus(1'b0, 12'h008, 32'h0, {1'b1, 32'h0});
      bus(1'b0, 12'h000, 32'h0, {28'h0, d[4:0]});
      for (i = 0; i < 4; i = i + 1) begin
         bus(1'b1, 12'h000, {24'h0, lv[8*i+:8]}, 33'h0);
         repeat (4) @(posedge clk_sys);
         cmp_pins(lx[8*i+:8], {clock_out_p, clock_out_n});
      end
      run(32'h0);
      kill_sec <= 1'b1;
      run(32'h2);
      kill_sec <= 1'b0;
      run(32'h1);
      kill_sec <= 1'b1;
      run(32'h2);
      kill_sec <= 1'b0;
      kill_pri <= 1'b1;
      bus(1'b1, 12'h000, 32'h0, 33'h0);
      bus(1'b1, 12'h000, 32'h1, 33'h0);
      run(32'h3);
      bus(1'b1, 12'h000, 32'h0, 33'h0);
      repeat (12) @(posedge clk_sys);
      bus(1'b0, 12'h004, 32'h0, {1'b0, 32'h10});
      bus(1'b1, 12'h000, 32'h2, 33'h0);
      bus(1'b0, 12'h004, 32'h0, {1'b0, 32'h20});
      cmp_pins(8'h0f, {clock_out_p, clock_out_n});
      final_report;
   end
endmodule // tb_top
`default_nettype wire
